/* core/pcgcfg_div.sv */
// Purpose: One output divider producing a square wave from oscillator ticks.
// Assumes: half is at least one tick and the block clears it on reset.
// Notes: Output toggles every half ticks, so the ratio is twice half.
`default_nettype none

module pcgcfg_div #(
  parameter int HALF_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic tick,
  input wire logic [HALF_W-1:0] half,
  output logic q
);

  logic [HALF_W-1:0] cnt_reg;
  logic q_reg;
  logic last;

  // A shrinking half must not strand the counter above the new limit.
  assign last = (cnt_reg >= half - 1'b1);
  assign q = q_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt_reg <= '0;
      q_reg <= 1'b0;
    end else if (tick) begin
      if (last) begin
        cnt_reg <= '0;
        q_reg <= ~q_reg;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_div_toggle;
    @(posedge aclk) disable iff (!aresetn)
      (tick && last && !clear) |=> (q_reg != $past(q_reg));
  endproperty
  a_div_toggle: assert property (p_div_toggle)
    else $error("divider output missed its toggle");

  property p_div_hold;
    @(posedge aclk) disable iff (!aresetn)
      (!tick && !clear) |=> $stable(q_reg);
  endproperty
  a_div_hold: assert property (p_div_hold)
    else $error("divider output moved without an oscillator tick");

endmodule : pcgcfg_div

`default_nettype wire

/* core/pcgcfg_top.sv */
// Purpose: Reference select, bypass, range pre-divide and bank dividers.
// Assumes: Reference and feedback pins are synchronous to aclk.
// Notes: In loop mode the oscillator is modelled as one tick per aclk.
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`default_nettype none

module pcgcfg_top #(
  parameter int POR_CYCLES = pcgcfg_pkg::POR_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pcgcfg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pcgcfg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_output_enable_n,
  input wire logic single_ended_ref_zero,
  input wire logic single_ended_ref_one,
  input wire logic diff_ref_in,
  input wire logic feedback_input,
  output logic [3:0] bank_a_outputs,
  output logic bank_a_oe,
  output logic [3:0] bank_b_outputs,
  output logic bank_b_oe,
  output logic [3:0] bank_c_outputs,
  output logic bank_c_oe,
  output logic feedback_output,
  output logic feedback_oe
);

  // ==========================================================================
  // AXI4-Lite slave
  // ==========================================================================
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic aw_held_reg, w_held_reg;
  logic [pcgcfg_pkg::ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [pcgcfg_pkg::CTRL_W-1:0] ctrl_reg;
  logic [pcgcfg_pkg::DIV_W-1:0] div_reg;
  logic [31:0] status_word;
  logic aw_fire, w_fire, do_write;

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  assign aw_fire = s_axi_awvalid && awready_reg;
  assign w_fire = s_axi_wvalid && wready_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (aw_fire) begin
      awready_reg <= 1'b0;
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (bvalid_reg && s_axi_bready) begin
      awready_reg <= 1'b1;
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_reg <= 1'b1;
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (w_fire) begin
      wready_reg <= 1'b0;
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (bvalid_reg && s_axi_bready) begin
      wready_reg <= 1'b1;
      w_held_reg <= 1'b0;
    end
  end

  // Response is raised one cycle after both halves of the write are held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= pcgcfg_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (aw_addr_reg == pcgcfg_pkg::ADDR_CTRL ||
                    aw_addr_reg == pcgcfg_pkg::ADDR_DIV) ?
                   pcgcfg_pkg::RESP_OKAY : pcgcfg_pkg::RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= pcgcfg_pkg::CTRL_RESET;
      div_reg <= pcgcfg_pkg::DIV_RESET;
    end else if (do_write) begin
      if (aw_addr_reg == pcgcfg_pkg::ADDR_CTRL && w_strb_reg[0]) begin
        ctrl_reg <= w_data_reg[pcgcfg_pkg::CTRL_W-1:0];
      end
      if (aw_addr_reg == pcgcfg_pkg::ADDR_DIV) begin
        if (w_strb_reg[0]) begin
          div_reg[7:0] <= w_data_reg[7:0];
        end
        if (w_strb_reg[1]) begin
          div_reg[8] <= w_data_reg[8];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= pcgcfg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= pcgcfg_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        pcgcfg_pkg::ADDR_CTRL: begin
          rdata_reg <= {26'h0, ctrl_reg};
        end
        pcgcfg_pkg::ADDR_DIV: begin
          rdata_reg <= {23'h0, div_reg};
        end
        pcgcfg_pkg::ADDR_STATUS: begin
          rdata_reg <= status_word;
        end
        default: begin
          rdata_reg <= '0;
          rresp_reg <= pcgcfg_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // ==========================================================================
  // Configuration fields
  // ==========================================================================
  logic ref_source, se_sel, range_high, loop_en, invert, soft_oe_n;
  logic [1:0] sel_a, sel_b, sel_c;
  logic [2:0] sel_fb;

  assign ref_source = ctrl_reg[pcgcfg_pkg::CTRL_REF_SRC_BIT];
  assign se_sel = ctrl_reg[pcgcfg_pkg::CTRL_SE_SEL_BIT];
  assign range_high = ctrl_reg[pcgcfg_pkg::CTRL_RANGE_BIT];
  assign loop_en = ctrl_reg[pcgcfg_pkg::CTRL_LOOP_EN_BIT];
  assign invert = ctrl_reg[pcgcfg_pkg::CTRL_INVERT_BIT];
  assign soft_oe_n = ctrl_reg[pcgcfg_pkg::CTRL_OE_N_BIT];
  assign sel_a = div_reg[pcgcfg_pkg::DIV_A_LSB +: 2];
  assign sel_b = div_reg[pcgcfg_pkg::DIV_B_LSB +: 2];
  assign sel_c = div_reg[pcgcfg_pkg::DIV_C_LSB +: 2];
  assign sel_fb = div_reg[pcgcfg_pkg::DIV_FB_LSB +: 3];

  // ==========================================================================
  // Power-up reset and device reset
  // ==========================================================================
  logic [pcgcfg_pkg::POR_CNT_W-1:0] por_cnt_reg;
  logic por_done_reg;
  logic dev_reset;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_cnt_reg <= '0;
      por_done_reg <= 1'b0;
    end else if (!por_done_reg) begin
      por_cnt_reg <= por_cnt_reg + 1'b1;
      if (por_cnt_reg == pcgcfg_pkg::POR_CNT_W'(POR_CYCLES - 1)) begin
        por_done_reg <= 1'b1;
      end
    end
  end

  // The pin and the software copy both hold the device in reset.
  assign dev_reset = !por_done_reg || !reset_output_enable_n ||
                     !soft_oe_n;

  // ==========================================================================
  // Reference select, bypass and range pre-divide
  // ==========================================================================
  logic ref_now, ref_prev_reg, ref_rise, osc_tick, div_tick, pre_reg;
  logic fb_prev_reg, fb_seen_reg;

  assign ref_now = ref_source ? diff_ref_in :
                   (se_sel ? single_ended_ref_one :
                    single_ended_ref_zero);
  assign ref_rise = ref_now && !ref_prev_reg;

  // An open loop in reset leaves the oscillator idle, its lowest rate.
  assign osc_tick = dev_reset ? 1'b0 :
                    (loop_en ? 1'b1 :
                     ref_rise);
  assign div_tick = range_high ? osc_tick : (osc_tick && pre_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_prev_reg <= 1'b0;
      fb_prev_reg <= 1'b0;
    end else begin
      ref_prev_reg <= ref_now;
      fb_prev_reg <= feedback_input;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || dev_reset) begin
      pre_reg <= 1'b0;
    end else if (osc_tick) begin
      pre_reg <= ~pre_reg;
    end
  end

  // Sticky sign that the external feedback path carries edges.
  always_ff @(posedge aclk) begin
    if (!aresetn || dev_reset) begin
      fb_seen_reg <= 1'b0;
    end else if (feedback_input && !fb_prev_reg) begin
      fb_seen_reg <= 1'b1;
    end
  end

  assign status_word = {28'h0000000, !loop_en, fb_seen_reg, por_done_reg,
                        !dev_reset};

  // ==========================================================================
  // Dividers
  // ==========================================================================
  logic [pcgcfg_pkg::HALF_W-1:0] half [4];
  logic [3:0] div_q;

  assign half[0] = pcgcfg_pkg::bank_half(pcgcfg_pkg::BANK_A, sel_a);
  assign half[1] = pcgcfg_pkg::bank_half(pcgcfg_pkg::BANK_B, sel_b);
  assign half[2] = pcgcfg_pkg::bank_half(pcgcfg_pkg::BANK_C, sel_c);
  assign half[3] = pcgcfg_pkg::HALF_FB[sel_fb];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_div
      pcgcfg_div #(
        .HALF_W(pcgcfg_pkg::HALF_W)
      ) u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(dev_reset),
        .tick(div_tick),
        .half(half[gi]),
        .q(div_q[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Output stage
  // ==========================================================================
  logic [3:0] out_a_reg, out_b_reg, out_c_reg;
  logic out_fb_reg, oe_reg;

  assign bank_a_outputs = out_a_reg;
  assign bank_b_outputs = out_b_reg;
  assign bank_c_outputs = out_c_reg;
  assign feedback_output = out_fb_reg;
  assign bank_a_oe = oe_reg;
  assign bank_b_oe = oe_reg;
  assign bank_c_oe = oe_reg;
  assign feedback_oe = oe_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= !dev_reset;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || dev_reset) begin
      out_a_reg <= 4'h0;
      out_b_reg <= 4'h0;
      out_c_reg <= 4'h0;
      out_fb_reg <= 1'b0;
    end else begin
      out_a_reg <= {4{div_q[0]}};
      out_b_reg <= {4{div_q[1]}};
      out_c_reg <= {{2{div_q[2] ^ invert}}, {2{div_q[2]}}};
      out_fb_reg <= div_q[3];
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_ref_select;
    @(posedge aclk) disable iff (!aresetn)
      !ref_source |-> (ref_now == (se_sel ? single_ended_ref_one :
                                   single_ended_ref_zero));
  endproperty
  a_ref_select: assert property (p_ref_select)
    else $error("wrong single-ended reference selected");

  property p_range_low;
    @(posedge aclk) disable iff (!aresetn)
      (!range_high && osc_tick ##1 !range_high && osc_tick) |->
        ($past(div_tick) != div_tick);
  endproperty
  a_range_low: assert property (p_range_low)
    else $error("low range did not halve the oscillator");

  property p_bypass;
    @(posedge aclk) disable iff (!aresetn)
      (!loop_en && !dev_reset) |->
        (osc_tick == (ref_now && !$past(ref_now)));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass did not follow the reference edges");

  property p_normal;
    @(posedge aclk) disable iff (!aresetn)
      (loop_en && !dev_reset) |-> osc_tick;
  endproperty
  a_normal: assert property (p_normal)
    else $error("oscillator stalled in loop mode");

  property p_invert;
    @(posedge aclk) disable iff (!aresetn)
      ($past(invert) && $past(!dev_reset)) |->
        (out_c_reg[3] != out_c_reg[1]);
  endproperty
  a_invert: assert property (p_invert)
    else $error("bank C upper pair not inverted");

  property p_tristate;
    @(posedge aclk) disable iff (!aresetn)
      !reset_output_enable_n |=> (!bank_a_oe && !bank_b_oe && !bank_c_oe &&
                                  !feedback_oe && out_a_reg == 4'h0);
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("outputs driven while reset pin low");

  property p_reset_idle;
    @(posedge aclk) disable iff (!aresetn)
      dev_reset [*2] |-> (!osc_tick && !pre_reg);
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("oscillator ran during reset");

  property p_por;
    @(posedge aclk) disable iff (!aresetn)
      $rose(por_done_reg) |-> $past(por_cnt_reg) ==
        pcgcfg_pkg::POR_CNT_W'(POR_CYCLES - 1);
  endproperty
  a_por: assert property (p_por)
    else $error("power-up reset length wrong");

  property p_por_hold;
    @(posedge aclk) disable iff (!aresetn)
      !por_done_reg |=> !oe_reg;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("outputs enabled before power-up reset ended");

  c_bypass_run: cover property (@(posedge aclk) disable iff (!aresetn)
    !loop_en && osc_tick);
  c_low_range: cover property (@(posedge aclk) disable iff (!aresetn)
    !range_high && div_tick);
  c_invert: cover property (@(posedge aclk) disable iff (!aresetn)
    invert && out_c_reg[3] && !out_c_reg[0]);
  c_fb_seen: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(fb_seen_reg));

endmodule : pcgcfg_top

`default_nettype wire

/* inc/pcgcfg_pkg.sv */
// Purpose: Shared constants and ratio decode for the clock divider block.
// Assumes: 32-bit AXI4-Lite register words on a 50 MHz aclk.
// Notes: Divide tables hold high-range ratios as half periods.
`default_nettype none

package pcgcfg_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DIV = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  localparam int CTRL_W = 6;
  localparam int CTRL_REF_SRC_BIT = 0;
  localparam int CTRL_SE_SEL_BIT = 1;
  localparam int CTRL_RANGE_BIT = 2;
  localparam int CTRL_LOOP_EN_BIT = 3;
  localparam int CTRL_INVERT_BIT = 4;
  localparam int CTRL_OE_N_BIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h3F;

  localparam int DIV_W = 9;
  localparam int DIV_A_LSB = 0;
  localparam int DIV_B_LSB = 2;
  localparam int DIV_C_LSB = 4;
  localparam int DIV_FB_LSB = 6;
  localparam logic [8:0] DIV_RESET = 9'h000;

  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_POR_BIT = 1;
  localparam int STAT_FB_SEEN_BIT = 2;
  localparam int STAT_BYPASS_BIT = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 20;
  localparam int POR_TIME_NS = 1000;
  localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CNT_W = 6;

  // ==========================================================================
  // Divider tables, high range, stored as half periods in oscillator ticks
  // ==========================================================================
  localparam int HALF_W = 4;
  localparam logic [3:0] HALF_A [4] = '{4'h2, 4'h3, 4'h4, 4'h6};
  localparam logic [3:0] HALF_B [4] = '{4'h2, 4'h3, 4'h4, 4'h5};
  localparam logic [3:0] HALF_C [4] = '{4'h1, 4'h2, 4'h3, 4'h4};
  localparam logic [3:0] HALF_FB [8] =
    '{4'h2, 4'h3, 4'h4, 4'h5, 4'h4, 4'h6, 4'h8, 4'hA};

  localparam logic [1:0] BANK_A = 2'h0;
  localparam logic [1:0] BANK_B = 2'h1;
  localparam logic [1:0] BANK_C = 2'h2;

  // Bank decode shared by the three output banks.
  function automatic logic [3:0] bank_half(input logic [1:0] bank,
                                           input logic [1:0] sel);
    logic [3:0] h;
    h = HALF_C[sel];
    if (bank == BANK_A) begin
      h = HALF_A[sel];
    end else if (bank == BANK_B) begin
      h = HALF_B[sel];
    end
    return h;
  endfunction : bank_half

endpackage : pcgcfg_pkg

`default_nettype wire

/* sim/pcgcfg_board.sv */
// Purpose: Board side model: reference clocks, feedback loop, reset pin.
// Assumes: Every pin changes just after a rising aclk edge.
// Notes: The feedback pin has a pull-down, so it reads low when undriven.
`default_nettype none

module pcgcfg_board (
  input wire logic aclk,
  input wire logic rst_req,
  input wire logic fb_out,
  input wire logic fb_oe,
  output logic ref_zero,
  output logic ref_one,
  output logic ref_diff,
  output logic fb_pin,
  output logic pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  int hold = 0;

  // ==========================================================================
  // Pins
  // ==========================================================================
  always_ff @(posedge aclk) begin
    cnt <= cnt + 1;
  end

  // Periods of 4, 6 and 8 cycles give each source a distinct signature.
  assign ref_zero = (cnt % 4) < 2;
  assign ref_one = (cnt % 6) < 3;
  assign ref_diff = (cnt % 8) < 4;

  // Ten cycles outlast the slowest reference period.
  always_ff @(posedge aclk) begin
    if (rst_req) begin
      hold <= 10;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end
  end

  assign pin_oe_n = (hold == 0);
  assign fb_pin = fb_oe ? fb_out : 1'b0;
endmodule : pcgcfg_board

`default_nettype wire

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the clock divider configuration block.
// Assumes: The board model owns the reference and reset pins.
// Notes: A short power-up count keeps the run brief.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POR = 4;
  logic aclk = 0;
  logic aresetn = 0;
  logic [3:0] aw = 0, ar = 0, ws = 0;
  logic [31:0] wd = 0;
  logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, rst_req = 0;
  logic awr, wr, bv, arr, rv, pin_n, r0, r1, rd, fbi, fbo;
  logic aoe, boe, coe, fboe;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] oa, ob, oc;
  wire [3:0] oe = {fboe, coe, boe, aoe};
  wire [3:0] mon = {fbo, oc[0], ob[0], oa[0]};
  int bad_count = 0, samples_checked = 0;

  pcgcfg_top #(.POR_CYCLES(POR)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ar), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .reset_output_enable_n(pin_n),
    .single_ended_ref_zero(r0), .single_ended_ref_one(r1),
    .diff_ref_in(rd), .feedback_input(fbi), .bank_a_outputs(oa),
    .bank_a_oe(aoe), .bank_b_outputs(ob), .bank_b_oe(boe),
    .bank_c_outputs(oc), .bank_c_oe(coe), .feedback_output(fbo),
    .feedback_oe(fboe));

  pcgcfg_board i_board (.aclk(aclk), .rst_req(rst_req), .fb_out(fbo),
    .fb_oe(fboe), .ref_zero(r0), .ref_one(r1), .ref_diff(rd),
    .fb_pin(fbi), .pin_oe_n(pin_n));

  initial begin
    forever #10 aclk = ~aclk;
  end

  // ==========================================================================
  // Checking and bus tasks
  // ==========================================================================
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic give_up();
    bad_count++;
    report_and_stop();
  endtask : give_up

  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk

  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    bit ad, dd, done;
    int n;
    ad = 0;
    dd = 0;
    done = 0;
    n = 0;
    @(posedge aclk);
    aw <= a;
    wd <= d;
    ws <= 4'hF;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    while (!done && n < 100) begin
      @(posedge aclk);
      n++;
      if (!ad && awr) begin
        ad = 1;
        awv <= 0;
      end
      if (!dd && wr) begin
        dd = 1;
        wv <= 0;
      end
      if (bv) begin
        done = 1;
        r = bresp;
        bre <= 0;
      end
    end
    if (!done) give_up();
  endtask : axw

  task automatic axr(input logic [3:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    bit got;
    int n;
    got = 0;
    n = 0;
    @(posedge aclk);
    ar <= a;
    arv <= 1;
    rre <= 1;
    while (!got && n < 100) begin
      @(posedge aclk);
      n++;
      if (arv && arr) arv <= 0;
      if (rv) begin
        got = 1;
        d = rdata;
        r = rresp;
        rre <= 0;
      end
    end
    if (!got) give_up();
  endtask : axr

  task automatic pulse();
    @(posedge aclk);
    rst_req <= 1;
    @(posedge aclk);
    rst_req <= 0;
  endtask : pulse

  // Dividers are only trusted after a reset that follows a change.
  task automatic cfg(input logic [5:0] c, input logic [31:0] dv);
    logic [1:0] r;
    axw(pcgcfg_pkg::ADDR_CTRL, {26'h0, c}, r);
    chk("ctrl_resp", r, pcgcfg_pkg::RESP_OKAY);
    axw(pcgcfg_pkg::ADDR_DIV, dv, r);
    chk("div_resp", r, pcgcfg_pkg::RESP_OKAY);
    pulse();
  endtask : cfg

  // Cycles between two rising edges of one monitored output.
  task automatic meas(input int b, output int p);
    int n, t;
    logic pv;
    n = 0;
    t = -1;
    p = 0;
    pv = 1;
    while (p == 0 && n < 400) begin
      @(negedge aclk);
      n++;
      if (!pv && mon[b] === 1'b1) begin
        if (t >= 0) p = n - t;
        t = n;
      end
      pv = mon[b];
    end
    if (p == 0) give_up();
  endtask : meas

  function automatic int ratio(int b, int s, bit hi);
    int t[4][8] = '{'{8, 12, 16, 24, 0, 0, 0, 0}, '{8, 12, 16, 20, 0, 0, 0, 0},
      '{4, 8, 12, 16, 0, 0, 0, 0}, '{8, 12, 16, 20, 16, 24, 32, 40}};
    return hi ? t[b][s] / 2 : t[b][s];
  endfunction : ratio

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [31:0] d, rnd;
    logic [1:0] r, a, b, c;
    int p;
    void'($urandom(74784));
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(negedge aclk);
    chk("oe_por", oe, 4'h0);
    repeat (POR + 6) @(negedge aclk);
    chk("oe_run", oe, 4'hF);
    axr(pcgcfg_pkg::ADDR_CTRL, d, r);
    chk("ctrl_rst", d, 32'h3F);
    axr(pcgcfg_pkg::ADDR_DIV, d, r);
    chk("div_rst", d, 32'h0);
    axw(4'hC, 32'hFFFFFFFF, r);
    chk("bad_wr", r, pcgcfg_pkg::RESP_SLVERR);
    axw(pcgcfg_pkg::ADDR_STATUS, 32'h0, r);
    chk("ro_wr", r, pcgcfg_pkg::RESP_SLVERR);
    axr(4'hC, d, r);
    chk("bad_rd", d, 32'h0);
    chk("bad_rresp", r, pcgcfg_pkg::RESP_SLVERR);
    axr(pcgcfg_pkg::ADDR_STATUS, d, r);
    chk("status", d, 32'h7);
    for (int h = 0; h < 2; h++) begin
      rnd = $urandom;
      for (int f = 0; f < 8; f++) begin
        a = f[1:0] ^ rnd[1:0];
        b = f[1:0] ^ rnd[3:2];
        c = f[1:0] ^ rnd[5:4];
        cfg({3'b111, h[0], 2'b11}, {rnd[31:9], f[2:0], c, b, a});
        axr(pcgcfg_pkg::ADDR_DIV, d, r);
        chk("div_rd", d, {23'h0, f[2:0], c, b, a});
        meas(0, p);
        chk("per_a", p, ratio(0, a, h[0]));
        meas(1, p);
        chk("per_b", p, ratio(1, b, h[0]));
        meas(2, p);
        chk("per_c", p, ratio(2, c, h[0]));
        meas(3, p);
        chk("per_fb", p, ratio(3, f, h[0]));
      end
    end
    for (int i = 0; i < 2; i++) begin
      cfg({1'b1, i[0], 4'hF}, 32'h0);
      meas(2, p);
      chk("per_c2", p, 32'd2);
      repeat (8) begin
        @(negedge aclk);
        chk("inv", oc[3:2], oc[1:0] ^ {2{i[0]}});
        chk("a_same", oa, {4{oa[0]}});
        chk("b_same", ob, {4{ob[0]}});
      end
    end
    // Bypass: bank C at ratio 2 runs at half the chosen reference rate.
    for (int s = 0; s < 3; s++) begin
      cfg({4'hD, s[0], s[1]}, 32'h0);
      meas(2, p);
      chk("bypass", p, 2 * (4 + 2 * s));
    end
    pulse();
    repeat (3) @(negedge aclk);
    chk("oe_rst", oe, 4'h0);
    chk("q_rst", {oa, ob, oc, fbo}, 13'h0);
    repeat (12) @(negedge aclk);
    chk("oe_back", oe, 4'hF);
    axw(pcgcfg_pkg::ADDR_CTRL, 32'h1F, r);
    repeat (2) @(negedge aclk);
    chk("oe_soft", oe, 4'h0);
    axw(pcgcfg_pkg::ADDR_CTRL, 32'h3F, r);
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire
